// *** verilog/mdu_map.svh ***
// mdu_map.svh: register indices, control fields and cycle counts of the unit.
// assumes inclusion by bare name; byte address of a register is four times its index.
`ifndef MDU_MAP_SVH
`define MDU_MAP_SVH

`define IDX_OPERAND1  3'd1
`define IDX_OPERAND2  3'd2
`define IDX_OPERAND3  3'd3
`define IDX_OPERAND4  3'd4
`define IDX_OPERAND5  3'd5
`define IDX_ARITH     3'd6
`define IDX_STATUS    3'd7
`define OPERAND_BYTES 6
`define ADDR_LIMIT    8'h20

`define CTL_ERR_BIT   7
`define CTL_OVF_BIT   6
`define CTL_DIR_BIT   5
`define ARITH_RST     6'h00

`define CYC_DIV32     6'd17
`define CYC_DIV16     6'd9
`define CYC_MUL       6'd11
`define CYC_SHIFT_MIN 6'd3
`define CYC_NORM_MIN  6'd4
`define MUL_LIMIT     32'h0000_ffff

`endif

// *** verilog/mdu_pkg.sv ***
// mdu_pkg: operation and sequencer state types of the multiply/divide unit.
// assumes nothing beyond a systemverilog compiler.
package mdu_pkg;
  typedef enum logic [2:0] {
    OP_DIV32 = 3'b000,
    OP_DIV16 = 3'b001,
    OP_MUL   = 3'b010,
    OP_SHIFT = 3'b011,
    OP_NORM  = 3'b100
  } op_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } run_state_t;
endpackage

// *** verilog/mdu_arith.sv ***
// mdu_arith: combinational result, flag and duration of one operation.
// assumes operands already hold the launching write; the caller latches outputs.
`include "mdu_map.svh"

module mdu_arith
  import mdu_pkg::*;
(
  // request
  input  wire logic [2:0]  op,
  input  wire logic [47:0] operand,
  input  wire logic [5:0]  ctl,
  // answer
  output logic      [47:0] result,
  output logic      [4:0]  count,
  output logic             ovf,
  output logic      [5:0]  cycles
);

  logic [31:0] dividend;
  logic [31:0] divisor;
  logic [31:0] quotient;
  logic [31:0] remainder;
  logic [31:0] product;
  logic [4:0]  zeros;

  // one cycle per two extra positions on top of the minimum
  function automatic logic [5:0] step_cycles(input logic [5:0] base, input logic [4:0] n);
    logic [4:0] extra;
    extra = (n == 5'd0) ? 5'd0 : 5'(n - 5'd1);
    step_cycles = base + {2'b00, extra[4:1]};
  endfunction

  // all-zero input stops at 31 positions
  function automatic logic [4:0] lead_zeros(input logic [31:0] v);
    lead_zeros = 5'd31;
    for (int i = 0; i < 32; i++)
    begin
      if (v[i])
        lead_zeros = 5'(31 - i);
    end
  endfunction

  always_comb
  begin
    result    = operand;
    count     = ctl[4:0];
    ovf       = 1'b0;
    cycles    = `CYC_DIV32;
    dividend  = (op == OP_DIV32) ? operand[31:0] : {16'h0000, operand[15:0]};
    divisor   = {16'h0000, operand[47:32]};
    quotient  = 32'hffff_ffff;
    remainder = dividend;
    product   = operand[15:0] * operand[47:32];
    zeros     = lead_zeros(operand[31:0]);
    if (divisor != 32'h0000_0000)
    begin
      quotient  = dividend / divisor;
      remainder = dividend % divisor;
    end
    case (op)
      OP_DIV32:
      begin
        result = {remainder[15:0], quotient};  // see [RULE_03]
        ovf    = (divisor == 32'h0000_0000);   // see [RULE_15]
        cycles = `CYC_DIV32;                   // see [RULE_07]
      end
      OP_DIV16:
      begin
        result = {remainder[15:0], operand[31:16], quotient[15:0]};  // see [RULE_04]
        ovf    = (divisor == 32'h0000_0000);                         // see [RULE_15]
        cycles = `CYC_DIV16;                                         // see [RULE_08]
      end
      OP_MUL:
      begin
        result = {operand[47:32], product};  // see [RULE_05]
        ovf    = (product > `MUL_LIMIT);     // see [RULE_15]
        cycles = `CYC_MUL;                   // see [RULE_09]
      end
      OP_SHIFT:
      begin
        // zeroes fill from whichever end is vacated
        result[31:0] = ctl[`CTL_DIR_BIT] ? (operand[31:0] >> ctl[4:0])
                                         : (operand[31:0] << ctl[4:0]);  // see [RULE_13]
        cycles       = step_cycles(`CYC_SHIFT_MIN, ctl[4:0]);            // see [RULE_10]
      end
      OP_NORM:
      begin
        result[31:0] = operand[31:0] << zeros;  // see [RULE_12]
        count        = zeros;                   // see [RULE_12]
        ovf          = operand[31];             // see [RULE_15]
        cycles       = step_cycles(`CYC_NORM_MIN, zeros);  // see [RULE_11]
      end
      default:
      begin
        result = operand;
      end
    endcase
  end

endmodule

// *** verilog/mdu_timer.sv ***
// mdu_timer: counts an operation's duration and flags its last cycle.
// assumes start is a one-cycle pulse on pclk; a start while running reloads.
`include "mdu_map.svh"

module mdu_timer
  import mdu_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic       start,
  input  wire logic [5:0] cycles,
  // status
  output logic            busy,
  output logic            fin
);

  run_state_t state;
  run_state_t next_state;
  logic [5:0] cnt;
  logic [5:0] next_cnt;

  always_comb
  begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      ST_IDLE:
      begin
        if (start)
        begin
          next_state = ST_RUN;
          next_cnt   = cycles;
        end
      end
      ST_RUN:
      begin
        if (start)
          next_cnt = cycles;
        else if (cnt == 6'd1)
        begin
          next_state = ST_IDLE;
          next_cnt   = 6'd0;
        end
        else
          next_cnt = cnt - 6'd1;
      end
      default:
      begin
        next_state = ST_IDLE;
        next_cnt   = 6'd0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_IDLE;
      cnt   <= 6'd0;
    end
    else
    begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  assign busy = (state == ST_RUN);
  assign fin  = (state == ST_RUN) && (cnt == 6'd1) && !start;

endmodule

// *** verilog/mul_div_unit.sv ***
// mul_div_unit: apb-mapped multiply, divide, shift and normalize sequencer.
// assumes an apb3 master on pclk; operand bytes sit in byte lane 0 of each word.
// Operation
// [RULE_01] software starts every operation by writing operand byte 0 first
// [RULE_02] writing byte 5 or arith control launches the selected operation
// [RULE_03] a byte 2 or 3 write in the sequence selects 32/16 division
// [RULE_04] byte 4 written last before byte 5, no byte 2 or 3: 16/16 division
// [RULE_05] byte 1 written last before byte 5: 16x16 multiply of bytes 1:0 by 5:4
// [RULE_06] the unit computes alone; bus accesses are never stalled by it
// [RULE_07] 32/16 division takes exactly 17 cycles
// [RULE_08] 16/16 division takes exactly 9 cycles
// [RULE_09] multiplication takes exactly 11 cycles
// [RULE_10] shift takes 3 cycles for count 1 up to 18 for count 31
// [RULE_11] normalize takes 4 cycles for one shift up to 19 for 31
// [RULE_12] normalize shifts left until bit 31 is set, stores count in control
// [RULE_13] shift moves the word by the control count, bit 5 picks right
// [RULE_14] operand reads while busy and checking set the error flag
// [RULE_15] overflow: divide by zero, product above 16 bits, normalizing top bit
// [RULE_16] results land back in the operand bytes when the count elapses
`include "mdu_map.svh"

module mul_div_unit
  import mdu_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb request
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  // apb answer
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  logic [7:0]  operand      [`OPERAND_BYTES];
  logic [7:0]  next_operand [`OPERAND_BYTES];
  logic [7:0]  wr_operand   [`OPERAND_BYTES];
  logic [5:0]  arith_ctl;
  logic [5:0]  next_arith_ctl;
  logic        err;
  logic        next_err;
  logic        ovf;
  logic        next_ovf;
  logic        check_en;
  logic        next_check_en;
  logic        seen_wide;
  logic        next_seen_wide;
  logic        seen_b4;
  logic        next_seen_b4;
  logic        seen_b1;
  logic        next_seen_b1;
  op_t         op_cur;
  op_t         next_op_cur;
  op_t         launch_op;
  logic [47:0] res_hold;
  logic [47:0] next_res_hold;
  logic [4:0]  cnt_hold;
  logic [4:0]  next_cnt_hold;
  logic        ovf_hold;
  logic        next_ovf_hold;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic [31:0] read_value;
  logic [2:0]  idx;
  logic        acc;
  logic        wr;
  logic        rd;
  logic        launch;
  logic        busy;
  logic        fin;
  logic [47:0] a_result;
  logic [4:0]  a_count;
  logic        a_ovf;
  logic [5:0]  a_cycles;

  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr < `ADDR_LIMIT) && (addr[1:0] == 2'b00);
  endfunction

  function automatic logic is_div(input op_t op);
    is_div = (op == OP_DIV32) || (op == OP_DIV16);
  endfunction

  // writes and reads act only at the edge that completes the access
  assign acc    = psel && penable && pready && is_mapped(paddr);
  assign wr     = acc && pwrite;
  assign rd     = acc && !pwrite;
  assign idx    = paddr[4:2];
  assign launch = wr && ((idx == `IDX_OPERAND5) || (idx == `IDX_ARITH));  // see [RULE_02]

  always_comb
  begin
    for (int i = 0; i < `OPERAND_BYTES; i++)
      wr_operand[i] = (wr && (idx == 3'(i))) ? pwdata[7:0] : operand[i];
    // a zero count in the control write means normalize
    if (idx == `IDX_ARITH)
      launch_op = (pwdata[4:0] == 5'd0) ? OP_NORM : OP_SHIFT;
    else if (seen_wide)
      launch_op = OP_DIV32;  // see [RULE_03]
    else if (seen_b1 && !seen_b4)
      launch_op = OP_MUL;    // see [RULE_05]
    else
      launch_op = OP_DIV16;  // see [RULE_04]
  end

  mdu_arith u_arith (
    .op      (launch_op),
    .operand ({wr_operand[5], wr_operand[4], wr_operand[3],
               wr_operand[2], wr_operand[1], wr_operand[0]}),
    .ctl     ((idx == `IDX_ARITH) ? pwdata[5:0] : arith_ctl),
    .result  (a_result),
    .count   (a_count),
    .ovf     (a_ovf),
    .cycles  (a_cycles)
  );

  mdu_timer u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (launch),
    .cycles  (a_cycles),
    .busy    (busy),
    .fin     (fin)
  );

  always_comb
  begin
    read_value = 32'h0000_0000;
    case (idx)
      `IDX_ARITH:
        read_value = {24'h00_0000, err, ovf, arith_ctl};
      `IDX_STATUS:
        read_value = {31'h0000_0000, busy};
      default:
        read_value = {24'h00_0000, operand[idx]};
    endcase
  end

  always_comb
  begin
    next_operand   = operand;
    next_arith_ctl = arith_ctl;
    next_err       = err;
    next_ovf       = ovf;
    next_check_en  = check_en;
    next_seen_wide = seen_wide;
    next_seen_b4   = seen_b4;
    next_seen_b1   = seen_b1;
    next_op_cur    = op_cur;
    next_res_hold  = res_hold;
    next_cnt_hold  = cnt_hold;
    next_ovf_hold  = ovf_hold;
    // registered answer one cycle into the access phase; the core never waits on a run
    next_pready    = psel && penable && !pready;  // see [RULE_06]
    next_pslverr   = next_pready && !is_mapped(paddr);
    // refused reads answer zero rather than an aliased register
    next_prdata    = next_pready ? (is_mapped(paddr) ? read_value : 32'h0000_0000) : prdata;
    if (fin)
    begin
      for (int i = 0; i < `OPERAND_BYTES; i++)
        next_operand[i] = res_hold[8*i +: 8];  // see [RULE_16]
      if (op_cur == OP_NORM)
        next_arith_ctl[4:0] = cnt_hold;        // see [RULE_12]
      next_ovf = ovf_hold;                     // see [RULE_15]
    end
    if (rd && (idx == `IDX_ARITH))
      next_err = 1'b0;                         // see [RULE_14]
    // the last result byte read closes the checking window
    if (rd && (((idx == `IDX_OPERAND5) && is_div(op_cur)) ||
               ((idx == `IDX_OPERAND3) && !is_div(op_cur))))
      next_check_en = 1'b0;
    if (wr)
    begin
      for (int i = 0; i < `OPERAND_BYTES; i++)
        next_operand[i] = wr_operand[i];
      case (idx)
        3'd0:
        begin
          // byte 0 opens a fresh sequence
          next_seen_wide = 1'b0;               // see [RULE_01]
          next_seen_b4   = 1'b0;
          next_seen_b1   = 1'b0;
          next_check_en  = 1'b1;
        end
        // the later of bytes 1 and 4 picks multiply or 16/16 division
        `IDX_OPERAND1:
        begin
          next_seen_b1 = 1'b1;                 // see [RULE_05]
          next_seen_b4 = 1'b0;
        end
        `IDX_OPERAND2, `IDX_OPERAND3:
          next_seen_wide = 1'b1;               // see [RULE_03]
        `IDX_OPERAND4:
        begin
          next_seen_b4 = 1'b1;                 // see [RULE_04]
          next_seen_b1 = 1'b0;
        end
        `IDX_ARITH:
          next_arith_ctl = pwdata[5:0];        // see [RULE_13]
        default:
          next_seen_b4 = seen_b4;
      endcase
      // writing into a running operation is flagged; only a byte 5 or control write restarts it
      if (busy && (idx != `IDX_STATUS))
        next_err = 1'b1;
    end
    if (launch)
    begin
      next_op_cur   = launch_op;               // see [RULE_02]
      next_res_hold = a_result;
      next_cnt_hold = a_count;
      next_ovf_hold = a_ovf;
    end
    // set wins over the clear by coming last
    if (rd && busy && check_en && (idx < `IDX_ARITH))
      next_err = 1'b1;                         // see [RULE_14]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < `OPERAND_BYTES; i++)
        operand[i] <= 8'h00;
      arith_ctl <= `ARITH_RST;
      err       <= 1'b0;
      ovf       <= 1'b0;
      check_en  <= 1'b0;
      seen_wide <= 1'b0;
      seen_b4   <= 1'b0;
      seen_b1   <= 1'b0;
      op_cur    <= OP_DIV32;
      res_hold  <= 48'h0000_0000_0000;
      cnt_hold  <= 5'd0;
      ovf_hold  <= 1'b0;
      prdata    <= 32'h0000_0000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
    end
    else
    begin
      operand   <= next_operand;
      arith_ctl <= next_arith_ctl;
      err       <= next_err;
      ovf       <= next_ovf;
      check_en  <= next_check_en;
      seen_wide <= next_seen_wide;
      seen_b4   <= next_seen_b4;
      seen_b1   <= next_seen_b1;
      op_cur    <= next_op_cur;
      res_hold  <= next_res_hold;
      cnt_hold  <= next_cnt_hold;
      ovf_hold  <= next_ovf_hold;
      prdata    <= next_prdata;
      pready    <= next_pready;
      pslverr   <= next_pslverr;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_launch(op_t op);
    launch && (launch_op == op);
  endsequence

  sequence s_quiet_launch(op_t op);
    launch && (launch_op == op) ##1 !launch [*8];
  endsequence

  // repetition counts stay small, so the long runs are built from pieces
  sequence s_quiet_nine;
    !launch [*8] ##1 !launch;
  endsequence

  a_div32_time: assert property (s_quiet_launch(OP_DIV32) ##1 s_quiet_nine // see [RULE_07]
                                 |-> fin ##1 !busy)
    else $error("32/16 division did not finish in 17 cycles");

  a_div16_time: assert property (s_quiet_launch(OP_DIV16) ##1 !launch // see [RULE_08]
                                 |-> fin ##1 !busy)
    else $error("16/16 division did not finish in 9 cycles");

  a_mul_time: assert property (s_quiet_launch(OP_MUL) ##1 !launch [*3] // see [RULE_09]
                               |-> fin ##1 !busy)
    else $error("multiplication did not finish in 11 cycles");

  a_shift_short: assert property (s_launch(OP_SHIFT) ##0 (pwdata[4:0] == 5'd1) // see [RULE_10]
                                  ##1 !launch [*3] |-> fin)
    else $error("shift by one did not finish in 3 cycles");

  a_norm_window: assert property (s_launch(OP_NORM) ##1 !launch [*3] // see [RULE_11]
                                  |-> !fin ##[1:16] fin)
    else $error("normalize duration outside 4 to 19 cycles");

  a_launch_busy: assert property (launch |=> busy) // see [RULE_02]
    else $error("launching write did not start the unit");

  a_err_set: assert property (rd && busy && check_en && (idx < `IDX_ARITH) |=> err) // see [RULE_14]
    else $error("operand read during a run did not flag an error");

  a_err_clear: assert property (rd && (idx == `IDX_ARITH) && !busy |=> !err) // see [RULE_14]
    else $error("control read did not clear the error flag");

  a_mul_ovf: assert property (fin && (op_cur == OP_MUL) // see [RULE_15]
                              |=> ovf == ($past(res_hold[31:16]) != 16'h0000))
    else $error("overflow flag wrong after multiplication");

  a_result_land: assert property (fin && !wr // see [RULE_16]
                                  |=> {operand[3], operand[2], operand[1], operand[0]}
                                  == $past(res_hold[31:0]))
    else $error("result did not land in operand bytes");

  a_no_stall: assert property (psel && penable && !pready |=> pready) // see [RULE_06]
    else $error("bus access was stalled");

endmodule

// *** tb/core_model.sv ***
// core_model: the controlling core, reaching the unit's registers as an apb master.
// assumes the bench calls xfer right after a rising pclk edge, one transfer at a time.
module core_model
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  // apb answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ns;

  // transfers whose answer never came; the bench counts them as mismatches
  int hangs;

  initial
  begin
    hangs   = 0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  // request held until pready is sampled high; bounded so a dead slave cannot hang us
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int t;
    t = 0;
    // one idle edge first, so back-to-back calls never drive psel twice in a time step
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++t < 50);
    if (pready !== 1'b1)
      hangs++;
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// *** tb/mul_div_unit_tb.sv ***
// mul_div_unit_tb: register-level tests of every operation and its duration, of overflow and of the error flag.
// assumes core_model as the only bus master and a 20 MHz pclk.
module mul_div_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          err_count;
  int          n_checks;
  logic [31:0] q;
  logic        e;

  mul_div_unit u_mul_div_unit (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );

  core_model u_core_model (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic test_done();
    err_count += u_core_model.hangs;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rb(input logic [2:0] i, input logic [31:0] exp);
    logic [31:0] r;
    logic        s;
    u_core_model.xfer(1'b0, {3'b000, i, 2'b00}, 32'h0000_0000, r, s);
    chk($sformatf("reg %0d", i), r, exp);
  endtask

  // result word lives in operand bytes 3..0
  task automatic wd(input logic [31:0] exp);
    for (int i = 0; i < 4; i++)
      rb(3'(i), {24'h00_0000, exp[8*i +: 8]});
  endtask

  task automatic seq(input logic [2:0] ix[6], input logic [7:0] dv[6], input int k);
    logic [31:0] r;
    logic        s;
    for (int i = 0; i < k; i++)
      u_core_model.xfer(1'b1, {3'b000, ix[i], 2'b00}, {24'h00_0000, dv[i]}, r, s);
  endtask

  // first status read lands in the last running cycle, the second after the finish
  task automatic run(input string nm, input logic [2:0] ix[6], input logic [7:0] dv[6],
                     input int k, input int n);
    seq(ix, dv, k);
    repeat (n - 3) @(posedge pclk);
    rb(3'd7, 32'h0000_0001);
    rb(3'd7, 32'h0000_0000);
    $display("test %s done", nm);
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    err_count++;
    test_done();
  end

  initial
  begin
    err_count = 0;
    n_checks  = 0;
    presetn   = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rb(3'd7, 32'h0000_0000);
    rb(3'd6, 32'h0000_0000);
    rb(3'd0, 32'h0000_0000);
    $display("test reset done");
    // multiply writes byte 4 before byte 1; the later of the two picks the operation
    run("mul", '{0, 4, 1, 5, 0, 0}, '{8'h34, 8'h02, 8'h12, 8'h00, 0, 0}, 4, 11);
    wd(32'h0000_2468);
    rb(3'd6, 32'h0000_0000);
    run("mul_ovf", '{0, 4, 1, 5, 0, 0}, '{8'hff, 8'hff, 8'hff, 8'hff, 0, 0}, 4, 11);
    wd(32'hfffe_0001);
    rb(3'd6, 32'h0000_0040);
    run("div16", '{0, 1, 4, 5, 0, 0}, '{8'h00, 8'h10, 8'h10, 8'h00, 0, 0}, 4, 9);
    wd(32'hfffe_0100);
    rb(3'd4, 32'h0000_0000);
    rb(3'd6, 32'h0000_0000);
    run("div32", '{0, 1, 2, 3, 4, 5}, '{8'h56, 8'h34, 8'h12, 8'h00, 8'h00, 8'h01}, 6, 17);
    wd(32'h0000_1234);
    rb(3'd4, 32'h0000_0056);
    rb(3'd5, 32'h0000_0000);
    run("div_zero", '{0, 1, 4, 5, 0, 0}, '{8'h78, 8'h56, 8'h00, 8'h00, 0, 0}, 4, 9);
    wd(32'h0000_ffff);
    rb(3'd4, 32'h0000_0078);
    rb(3'd5, 32'h0000_0056);
    rb(3'd6, 32'h0000_0040);
    run("shr31", '{0, 1, 2, 3, 6, 0}, '{8'h00, 8'h00, 8'h00, 8'h80, 8'h3f, 0}, 5, 18);
    wd(32'h0000_0001);
    rb(3'd6, 32'h0000_003f);
    run("shl1", '{0, 1, 2, 3, 6, 0}, '{8'h78, 8'h56, 8'h34, 8'h12, 8'h01, 0}, 5, 3);
    wd(32'h2468_acf0);
    run("norm31", '{0, 1, 2, 3, 6, 0}, '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 0}, 5, 19);
    wd(32'h8000_0000);
    rb(3'd6, 32'h0000_001f);
    run("norm_top", '{0, 1, 2, 3, 6, 0}, '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 0}, 5, 4);
    wd(32'h8000_0000);
    rb(3'd6, 32'h0000_0040);
    // operand peek mid-run must flag, not disturb the product
    seq('{0, 4, 1, 5, 0, 0}, '{8'h03, 8'h05, 8'h00, 8'h00, 0, 0}, 4);
    u_core_model.xfer(1'b0, 8'h00, 32'h0000_0000, q, e);
    repeat (20) @(posedge pclk);
    wd(32'h0000_000f);
    rb(3'd6, 32'h0000_0080);
    rb(3'd6, 32'h0000_0000);
    $display("test error_flag done");
    // a write into a running product is flagged; the result still lands over it
    seq('{0, 4, 1, 5, 0, 0}, '{8'h03, 8'h05, 8'h00, 8'h00, 0, 0}, 4);
    u_core_model.xfer(1'b1, 8'h08, 32'h0000_00aa, q, e);
    repeat (20) @(posedge pclk);
    wd(32'h0000_000f);
    rb(3'd6, 32'h0000_0080);
    $display("test write_flag done");
    u_core_model.xfer(1'b0, 8'h20, 32'h0000_0000, q, e);
    chk("unmapped data", q, 32'h0000_0000);
    chk("unmapped slverr", {31'h0, e}, 32'h0000_0001);
    u_core_model.xfer(1'b1, 8'h1c, 32'h0000_0001, q, e);
    rb(3'd7, 32'h0000_0000);
    $display("test unmapped done");
    test_done();
  end
endmodule
